/* hw/etp_pkg.sv */
// Package: register map, field positions and reset values of the block
package etp_pkg;

	// ****************************************************************
	// Bus widths
	// ****************************************************************
	localparam int unsigned ETP_AW = 4;
	localparam int unsigned ETP_DW = 16;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [ETP_AW-1:0] ETP_OFS_SELECT   = 4'h0;
	localparam logic [ETP_AW-1:0] ETP_OFS_PRESCALE = 4'h1;
	localparam logic [ETP_AW-1:0] ETP_OFS_FLAGS    = 4'h2;
	localparam logic [ETP_AW-1:0] ETP_OFS_CLEAR    = 4'h3;
	localparam logic [ETP_AW-1:0] ETP_OFS_FORCE    = 4'h4;
	localparam logic [ETP_AW-1:0] ETP_OFS_MASK     = 4'h5;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	// Flag, clear, force and mask registers share one layout
	localparam int unsigned ETP_BIT_IRQ    = 0;
	localparam int unsigned ETP_BIT_CONV_A = 2;
	localparam int unsigned ETP_BIT_CONV_B = 3;
	// Select register
	localparam int unsigned ETP_SEL_IRQ_EN    = 0;
	localparam int unsigned ETP_SEL_CONV_A_EN = 1;
	localparam int unsigned ETP_SEL_CONV_B_EN = 2;
	localparam int unsigned ETP_SEL_W         = 3;
	// Prescale register
	localparam int unsigned ETP_PRD_LSB = 0;
	localparam int unsigned ETP_CNT_LSB = 2;
	localparam int unsigned ETP_CNT_W   = 2;
	localparam int unsigned ETP_FLG_W   = 4;

	// ****************************************************************
	// Reset values and constants
	// ****************************************************************
	localparam logic [ETP_SEL_W-1:0] ETP_SEL_RST  = 3'h0;
	localparam logic [ETP_CNT_W-1:0] ETP_PRD_RST  = 2'h0;
	localparam logic [ETP_CNT_W-1:0] ETP_CNT_RST  = 2'h0;
	localparam logic [ETP_CNT_W-1:0] ETP_CNT_MAX  = 2'h3;
	localparam logic [ETP_CNT_W-1:0] ETP_CNT_ONE  = 2'h1;
	localparam logic [ETP_FLG_W-1:0] ETP_MASK_RST = 4'h0;
	// Mask bit 1 has no flag behind it and always reads zero
	localparam logic [ETP_FLG_W-1:0] ETP_FLG_KEEP = 4'hd;
	localparam logic [ETP_DW-1:0]    ETP_RD_ZERO  = 16'h0000;

endpackage : etp_pkg

/* hw/etp_flag.sv */
// Sticky status flag with set priority over clear
`timescale 1ns/1ps
module etp_flag
	import etp_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o
);

	typedef struct packed {
		logic flag;
	} etp_flag_st_t;

	etp_flag_st_t st_q;
	etp_flag_st_t st_d;

	// An event landing in the clear cycle must not be lost
	always_comb begin
		st_d = st_q;
		if (clr_i) begin
			st_d.flag = 1'b0;
		end
		if (set_i) begin
			st_d.flag = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign flag_o = st_q.flag;

endmodule : etp_flag

/* hw/etp_conv_chan.sv */
// Conversion-start channel: gated one-cycle start pulse
`timescale 1ns/1ps
module etp_conv_chan
	import etp_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic trig_i,
	input  wire logic force_i,
	input  wire logic en_i,
	output logic      set_o,
	output logic      start_o
);

	typedef struct packed {
		logic start;
	} etp_conv_st_t;

	etp_conv_st_t st_q;
	etp_conv_st_t st_d;

	// Flag never gates the pulse; a force marks the flag even if disabled
	assign set_o = (trig_i & en_i) | force_i;

	always_comb begin
		st_d       = st_q;
		st_d.start = (trig_i | force_i) & en_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign start_o = st_q.start;

endmodule : etp_conv_chan

/* hw/etp_trigger.sv */
// Event-trigger block: interrupt prescaler, latched flags, register port
`timescale 1ns/1ps

// Notes on behaviour
// [RQ1] Period written equal to count fires at once
// [RQ2] Software never writes period below count
// [RQ3] Event during period write still increments count
// [RQ4] Period zero: no count, request, force
// [RQ5] Request on first, second or third event
// [RQ6] Start B pulse sets flag, keeps pulsing
// [RQ7] Start A pulse sets flag, keeps pulsing
// [RQ8] Request sets flag; none more until cleared
// [RQ9] One pending request waits for flag clear
// [RQ10] Count clears on request, saturates when blocked
// [RQ11] Requests only while interrupt enable set
// [RQ12] Clear bit one clears flag, reads zero
// [RQ13] Force sets flag; request only if enabled
// [RQ14] One-cycle pulses, zero resets, reserved zero
module etp_trigger
	import etp_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [ETP_AW-1:0] addr_i,
	input  wire logic [ETP_DW-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [ETP_DW-1:0] rdata_o,
	input  wire logic              irq_event_i,
	input  wire logic              conv_a_event_i,
	input  wire logic              conv_b_event_i,
	output logic                   module_irq_request_o,
	output logic                   conversion_start_a_o,
	output logic                   conversion_start_b_o,
	output logic                   irq_o
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [ETP_SEL_W-1:0] sel;
		logic [ETP_CNT_W-1:0] prd;
		logic [ETP_CNT_W-1:0] cnt;
		logic [ETP_FLG_W-1:0] mask;
		logic                 req;
		logic [ETP_DW-1:0]    rdata;
	} etp_state_t;

	etp_state_t st_q;
	etp_state_t st_d;

	logic                 prd_wr;
	logic                 clr_wr;
	logic                 frc_wr;
	logic [ETP_CNT_W-1:0] prd_new;
	logic                 cnt_inc;
	logic [ETP_CNT_W-1:0] cnt_a;
	logic                 reached;
	logic                 irq_en;
	logic                 irq_flag;
	logic                 irq_force;
	logic                 fire;
	logic                 conv_a_set;
	logic                 conv_b_set;
	logic                 conv_a_flag;
	logic                 conv_b_flag;
	logic [ETP_FLG_W-1:0] flags;

	// ****************************************************************
	// Write decode
	// ****************************************************************
	assign prd_wr = wr_i && (addr_i == ETP_OFS_PRESCALE);
	assign clr_wr = wr_i && (addr_i == ETP_OFS_CLEAR);
	assign frc_wr = wr_i && (addr_i == ETP_OFS_FORCE);
	assign irq_en = st_q.sel[ETP_SEL_IRQ_EN];

	// ****************************************************************
	// Interrupt prescaler
	// ****************************************************************
	// Period is undefined below the count; only equality is compared
	assign prd_new = prd_wr ? wdata_i[ETP_PRD_LSB +: ETP_CNT_W] : st_q.prd; // RQ2
	// A write in the event cycle never swallows the event
	assign cnt_inc = irq_event_i && (st_q.cnt != ETP_CNT_MAX) &&
		(prd_wr || ((st_q.prd != ETP_PRD_RST) &&
		(st_q.cnt != st_q.prd))); // RQ3 RQ4 RQ10
	assign cnt_a = cnt_inc ? st_q.cnt + ETP_CNT_ONE : st_q.cnt; // RQ3
	assign reached = (prd_new != ETP_PRD_RST) && (cnt_a == prd_new); // RQ1 RQ5
	assign irq_force = frc_wr && wdata_i[ETP_BIT_IRQ] &&
		(prd_new != ETP_PRD_RST); // RQ4 RQ13
	// Saturated count while flagged is the single pending request
	assign fire = irq_en && !irq_flag && (reached || irq_force); // RQ8 RQ9 RQ11

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_d     = st_q;
		st_d.req = fire; // RQ14
		st_d.cnt = fire ? ETP_CNT_RST : cnt_a; // RQ10
		if (wr_i) begin
			unique case (addr_i)
				ETP_OFS_SELECT: begin
					st_d.sel = wdata_i[ETP_SEL_W-1:0];
				end
				ETP_OFS_PRESCALE: begin
					st_d.prd = wdata_i[ETP_PRD_LSB +: ETP_CNT_W];
				end
				ETP_OFS_MASK: begin
					st_d.mask = wdata_i[ETP_FLG_W-1:0] & ETP_FLG_KEEP;
				end
				default: begin
				end
			endcase
		end
		st_d.rdata = ETP_RD_ZERO;
		if (rd_i) begin
			unique case (addr_i)
				ETP_OFS_SELECT: begin
					st_d.rdata[ETP_SEL_W-1:0] = st_q.sel;
				end
				ETP_OFS_PRESCALE: begin
					st_d.rdata[ETP_PRD_LSB +: ETP_CNT_W] = st_q.prd;
					st_d.rdata[ETP_CNT_LSB +: ETP_CNT_W] = st_q.cnt;
				end
				ETP_OFS_FLAGS: begin
					st_d.rdata[ETP_FLG_W-1:0] = flags; // RQ14
				end
				ETP_OFS_MASK: begin
					st_d.rdata[ETP_FLG_W-1:0] = st_q.mask;
				end
				// Clear, force and unmapped offsets read zero
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q.sel   <= ETP_SEL_RST;
			st_q.prd   <= ETP_PRD_RST;
			st_q.cnt   <= ETP_CNT_RST;
			st_q.mask  <= ETP_MASK_RST;
			st_q.req   <= 1'b0;
			st_q.rdata <= ETP_RD_ZERO;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// Flags and conversion-start channels
	// ****************************************************************
	etp_flag u_irq_flag (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.set_i  (fire | irq_force), // RQ8 RQ13
		.clr_i  (clr_wr && wdata_i[ETP_BIT_IRQ]), // RQ12
		.flag_o (irq_flag)
	);

	etp_conv_chan u_conv_a (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.trig_i  (conv_a_event_i),
		.force_i (frc_wr && wdata_i[ETP_BIT_CONV_A]),
		.en_i    (st_q.sel[ETP_SEL_CONV_A_EN]),
		.set_o   (conv_a_set),
		.start_o (conversion_start_a_o)
	);

	etp_flag u_conv_a_flag (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.set_i  (conv_a_set), // RQ7
		.clr_i  (clr_wr && wdata_i[ETP_BIT_CONV_A]),
		.flag_o (conv_a_flag)
	);

	etp_conv_chan u_conv_b (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.trig_i  (conv_b_event_i),
		.force_i (frc_wr && wdata_i[ETP_BIT_CONV_B]),
		.en_i    (st_q.sel[ETP_SEL_CONV_B_EN]),
		.set_o   (conv_b_set),
		.start_o (conversion_start_b_o)
	);

	etp_flag u_conv_b_flag (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.set_i  (conv_b_set), // RQ6
		.clr_i  (clr_wr && wdata_i[ETP_BIT_CONV_B]),
		.flag_o (conv_b_flag)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign flags = {conv_b_flag, conv_a_flag, 1'b0, irq_flag};
	assign irq_o = |(flags & st_q.mask);
	assign module_irq_request_o = st_q.req;
	assign rdata_o = st_q.rdata;

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_EQ_WRITE_FIRES: assert property ( // RQ1
		@(posedge clk_i) disable iff (rst_i)
		(prd_wr && !irq_event_i && irq_en && !irq_flag &&
		(wdata_i[ETP_CNT_W-1:0] == st_q.cnt) &&
		(wdata_i[ETP_CNT_W-1:0] != ETP_PRD_RST)) |=> module_irq_request_o
	) else $error("Period equal to count did not fire");

	AST_WRITE_KEEPS_EVENT: assert property ( // RQ3
		@(posedge clk_i) disable iff (rst_i)
		(prd_wr && irq_event_i && (st_q.cnt != ETP_CNT_MAX)) |=>
		((st_q.cnt == $past(st_q.cnt) + ETP_CNT_ONE) || module_irq_request_o)
	) else $error("Event lost during period write");

	AST_ZERO_PERIOD_IDLE: assert property ( // RQ4
		@(posedge clk_i) disable iff (rst_i)
		((st_q.prd == ETP_PRD_RST) && !wr_i && !irq_flag) |=>
		(!module_irq_request_o && $stable(st_q.cnt))
	) else $error("Zero period still counts or requests");

	AST_ZERO_PERIOD_NO_FORCE: assert property ( // RQ4
		@(posedge clk_i) disable iff (rst_i)
		(frc_wr && (st_q.prd == ETP_PRD_RST) && !irq_flag) |=> !irq_flag
	) else $error("Force honoured with zero period");

	AST_NTH_EVENT_FIRES: assert property ( // RQ5
		@(posedge clk_i) disable iff (rst_i)
		(!wr_i && irq_en && !irq_flag && irq_event_i &&
		(st_q.prd != ETP_PRD_RST) &&
		(st_q.cnt + ETP_CNT_ONE == st_q.prd)) |=> module_irq_request_o
	) else $error("Selected event did not fire");

	AST_CONV_B_PULSE: assert property ( // RQ6
		@(posedge clk_i) disable iff (rst_i)
		(conv_b_event_i && st_q.sel[ETP_SEL_CONV_B_EN]) |=>
		(conversion_start_b_o && conv_b_flag)
	) else $error("Start B pulse or flag missing");

	AST_CONV_A_PULSE: assert property ( // RQ7
		@(posedge clk_i) disable iff (rst_i)
		(conv_a_event_i && st_q.sel[ETP_SEL_CONV_A_EN] && conv_a_flag) |=>
		(conversion_start_a_o && conv_a_flag)
	) else $error("Start A suppressed by its flag");

	AST_FLAG_BLOCKS: assert property ( // RQ8
		@(posedge clk_i) disable iff (rst_i)
		module_irq_request_o |-> (irq_flag && !$past(irq_flag))
	) else $error("Request while flag was set");

	AST_PENDING_AFTER_CLEAR: assert property ( // RQ9
		@(posedge clk_i) disable iff (rst_i)
		(clr_wr && wdata_i[ETP_BIT_IRQ] && irq_flag && irq_en &&
		(st_q.prd != ETP_PRD_RST) && (st_q.cnt == st_q.prd)) |=>
		(wr_i or (##1 module_irq_request_o))
	) else $error("Pending request not issued after clear");

	AST_COUNT_CLEARS: assert property ( // RQ10
		@(posedge clk_i) disable iff (rst_i)
		module_irq_request_o |-> (st_q.cnt == ETP_CNT_RST)
	) else $error("Count not cleared on request");

	AST_COUNT_HOLDS: assert property ( // RQ10
		@(posedge clk_i) disable iff (rst_i)
		(irq_flag && !wr_i && (st_q.cnt == st_q.prd)) |=> $stable(st_q.cnt)
	) else $error("Blocked count moved past period");

	AST_ENABLE_GATES: assert property ( // RQ11
		@(posedge clk_i) disable iff (rst_i)
		(!irq_en && !wr_i) |=> !module_irq_request_o
	) else $error("Request while disabled");

	AST_CLEAR_FLAG: assert property ( // RQ12
		@(posedge clk_i) disable iff (rst_i)
		(clr_wr && wdata_i[ETP_BIT_IRQ]) |=>
		// A request fired in the clear cycle sets the flag again
		(!irq_flag || module_irq_request_o)
	) else $error("Clear did not drop the flag");

	AST_FORCE_FLAG: assert property ( // RQ13
		@(posedge clk_i) disable iff (rst_i)
		irq_force |=> (irq_flag &&
		(module_irq_request_o == $past(irq_en && !irq_flag)))
	) else $error("Force flag or request wrong");

	AST_ONE_CYCLE_REQ: assert property ( // RQ14
		@(posedge clk_i) disable iff (rst_i)
		module_irq_request_o |=> !module_irq_request_o
	) else $error("Request longer than one cycle");

	AST_RESERVED_ZERO: assert property ( // RQ14
		@(posedge clk_i) disable iff (rst_i)
		(rd_i && ((addr_i == ETP_OFS_FLAGS) || (addr_i == ETP_OFS_CLEAR))) |=>
		((rdata_o[ETP_DW-1:ETP_FLG_W] == 12'h000) && !rdata_o[1] &&
		((rdata_o == ETP_RD_ZERO) || ($past(addr_i) == ETP_OFS_FLAGS)))
	) else $error("Reserved or clear bits read nonzero");

endmodule : etp_trigger

/* tb/etp_sink.sv */
// Downstream partner model: counts request and start pulses
`timescale 1ns/1ps
module etp_sink (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       req_i,
	input  wire logic       start_a_i,
	input  wire logic       start_b_i,
	output logic      [7:0] req_cnt_o,
	output logic      [7:0] a_cnt_o,
	output logic      [7:0] b_cnt_o,
	output logic      [7:0] long_cnt_o
);
	// ****************************************************************
	// Pulse counters
	// ****************************************************************
	logic [2:0] prev_q;
	// A high level seen on two edges in a row counts as a long pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_cnt_o  <= 8'h00;
			a_cnt_o    <= 8'h00;
			b_cnt_o    <= 8'h00;
			long_cnt_o <= 8'h00;
			prev_q     <= 3'h0;
		end else begin
			req_cnt_o  <= req_cnt_o + 8'(req_i);
			a_cnt_o    <= a_cnt_o + 8'(start_a_i);
			b_cnt_o    <= b_cnt_o + 8'(start_b_i);
			long_cnt_o <= long_cnt_o + 8'(|(prev_q & {req_i, start_a_i, start_b_i}));
			prev_q     <= {req_i, start_a_i, start_b_i};
		end
	end
endmodule : etp_sink

/* tb/etp_trigger_test.sv */
// Self-checking bench for the event-trigger block
`timescale 1ns/1ps
module etp_trigger_test;
	import etp_pkg::*;
	logic              clk_i;
	logic              rst_i;
	logic [ETP_AW-1:0] addr_i;
	logic [ETP_DW-1:0] wdata_i;
	logic              wr_i;
	logic              rd_i;
	logic [ETP_DW-1:0] rdata_o;
	logic              irq_event_i;
	logic              conv_a_event_i;
	logic              conv_b_event_i;
	logic              module_irq_request_o;
	logic              conversion_start_a_o;
	logic              conversion_start_b_o;
	logic              irq_o;
	logic [7:0]        req_cnt;
	logic [7:0]        a_cnt;
	logic [7:0]        b_cnt;
	logic [7:0]        long_cnt;
	logic [15:0]       nreq;
	int                error_cnt;
	int                checks;

	etp_trigger etp_trigger_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.irq_event_i(irq_event_i), .conv_a_event_i(conv_a_event_i),
		.conv_b_event_i(conv_b_event_i),
		.module_irq_request_o(module_irq_request_o),
		.conversion_start_a_o(conversion_start_a_o),
		.conversion_start_b_o(conversion_start_b_o), .irq_o(irq_o));
	etp_sink etp_sink_i (.clk_i(clk_i), .rst_i(rst_i),
		.req_i(module_irq_request_o), .start_a_i(conversion_start_a_o),
		.start_b_i(conversion_start_b_o), .req_cnt_o(req_cnt),
		.a_cnt_o(a_cnt), .b_cnt_o(b_cnt), .long_cnt_o(long_cnt));

	always #50 clk_i = ~clk_i;

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	// Optional event pulse rides in the same cycle as the write
	task automatic wr(input logic [3:0] a, input logic [15:0] d,
		input logic e = 1'b0);
		@(posedge clk_i);
		addr_i      <= a;
		wdata_i     <= d;
		wr_i        <= 1'b1;
		irq_event_i <= e;
		@(posedge clk_i);
		wr_i        <= 1'b0;
		irq_event_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask : rd

	// Events are spaced by one idle cycle
	task automatic ev(input int n);
		repeat (n) begin
			@(posedge clk_i);
			irq_event_i <= 1'b1;
			@(posedge clk_i);
			irq_event_i <= 1'b0;
		end
	endtask : ev

	task automatic cev(input logic a, input logic b);
		@(posedge clk_i);
		conv_a_event_i <= a;
		conv_b_event_i <= b;
		@(posedge clk_i);
		conv_a_event_i <= 1'b0;
		conv_b_event_i <= 1'b0;
	endtask : cev

	task automatic req_is(input int add);
		nreq = nreq + 16'(add);
		repeat (3) @(posedge clk_i);
		#1;
		chk({8'h00, req_cnt}, nreq);
	endtask : req_is

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		give_verdict();
	end

	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		addr_i = 4'h0;
		wdata_i = 16'h0000;
		wr_i = 1'b0;
		rd_i = 1'b0;
		irq_event_i = 1'b0;
		conv_a_event_i = 1'b0;
		conv_b_event_i = 1'b0;
		nreq = 16'h0000;
		error_cnt = 0;
		checks = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 16; a++) rd(4'(a), 16'h0000);
		wr(ETP_OFS_SELECT, 16'h0001);
		ev(2);
		rd(ETP_OFS_PRESCALE, 16'h0000);
		wr(ETP_OFS_FORCE, 16'h0001);
		rd(ETP_OFS_FLAGS, 16'h0000);
		req_is(0);
		for (int p = 1; p < 4; p++) begin
			wr(ETP_OFS_PRESCALE, 16'(p));
			ev(p - 1);
			rd(ETP_OFS_PRESCALE, 16'(p) | 16'((p - 1) << 2));
			ev(1);
			req_is(1);
			rd(ETP_OFS_PRESCALE, 16'(p));
			rd(ETP_OFS_FLAGS, 16'h0001);
			wr(ETP_OFS_CLEAR, 16'h0001);
			rd(ETP_OFS_FLAGS, 16'h0000);
		end
		wr(ETP_OFS_PRESCALE, 16'h0001);
		ev(1);
		req_is(1);
		ev(3);
		req_is(0);
		rd(ETP_OFS_PRESCALE, 16'h0005);
		wr(ETP_OFS_CLEAR, 16'h0000);
		rd(ETP_OFS_FLAGS, 16'h0001);
		wr(ETP_OFS_CLEAR, 16'h0001);
		req_is(1);
		rd(ETP_OFS_FLAGS, 16'h0001);
		rd(ETP_OFS_PRESCALE, 16'h0001);
		wr(ETP_OFS_CLEAR, 16'h0001);
		wr(ETP_OFS_SELECT, 16'h0000);
		wr(ETP_OFS_PRESCALE, 16'h0003);
		ev(2);
		rd(ETP_OFS_PRESCALE, 16'h000b);
		wr(ETP_OFS_SELECT, 16'h0001);
		req_is(0);
		wr(ETP_OFS_PRESCALE, 16'h0002);
		req_is(1);
		rd(ETP_OFS_PRESCALE, 16'h0002);
		wr(ETP_OFS_CLEAR, 16'h0001);
		// Period written together with an event, zero then nonzero
		wr(ETP_OFS_PRESCALE, 16'h0000, 1'b1);
		rd(ETP_OFS_PRESCALE, 16'h0004);
		wr(ETP_OFS_PRESCALE, 16'h0003, 1'b1);
		rd(ETP_OFS_PRESCALE, 16'h000b);
		ev(1);
		req_is(1);
		wr(ETP_OFS_CLEAR, 16'h0001);
		wr(ETP_OFS_FORCE, 16'h0001);
		req_is(1);
		wr(ETP_OFS_CLEAR, 16'h0001);
		wr(ETP_OFS_SELECT, 16'h0000);
		wr(ETP_OFS_FORCE, 16'h0001);
		req_is(0);
		rd(ETP_OFS_FLAGS, 16'h0001);
		wr(ETP_OFS_MASK, 16'h000f);
		#1;
		chk(16'(irq_o), 16'h0001);
		rd(ETP_OFS_MASK, 16'h000d);
		wr(ETP_OFS_MASK, 16'h0000);
		#1;
		chk(16'(irq_o), 16'h0000);
		wr(ETP_OFS_MASK, 16'h0001);
		wr(ETP_OFS_CLEAR, 16'h0001);
		#1;
		chk(16'(irq_o), 16'h0000);
		wr(ETP_OFS_SELECT, 16'h0006);
		cev(1'b1, 1'b0);
		cev(1'b1, 1'b0);
		cev(1'b0, 1'b1);
		cev(1'b1, 1'b1);
		rd(ETP_OFS_FLAGS, 16'h000c);
		cev(1'b0, 1'b1);
		rd(ETP_OFS_FLAGS, 16'h000c);
		chk({8'h00, a_cnt}, 16'h0003);
		chk({8'h00, b_cnt}, 16'h0003);
		wr(ETP_OFS_CLEAR, 16'h000c);
		wr(ETP_OFS_FLAGS, 16'h000f);
		rd(ETP_OFS_FLAGS, 16'h0000);
		wr(ETP_OFS_SELECT, 16'h0000);
		wr(ETP_OFS_FORCE, 16'h000c);
		rd(ETP_OFS_FLAGS, 16'h000c);
		chk({8'h00, a_cnt}, 16'h0003);
		wr(ETP_OFS_SELECT, 16'h0006);
		wr(ETP_OFS_FORCE, 16'h0004);
		req_is(0);
		chk({8'h00, a_cnt}, 16'h0004);
		chk({8'h00, long_cnt}, 16'h0000);
		give_verdict();
	end
endmodule : etp_trigger_test
